// ===== aas_aux_adc_seq.sv
// Auxiliary converter sequencer with serial instruction port and result readout.
//
// Function
// - Start bit write launches conversion sequence.
// - Start bit clears itself when sequence ends.
// - Start writes ignored while sequence runs.
// - Reference bit: 0 bandgap, 1 analog supply.
// - Two-bit field steers four-way input mux.
// - Average code gives 1 to 32 conversions.
// - Twelve conversion clock edges per conversion.
// - Each averaged conversion also takes twelve edges.
// - Conversion clock derived from system clock divider.
// - Output driven high as busy at start.
// - Completion stores result, output driven low unless a select rise during the run has floated it.
// - Readout enabled: result shown after chip-select fall.
// - Result shifted MSB first on clock fall.
// - Output floats when chip select rises, except on the rise that launches a sequence.
// - Readout disabled: no result on output.
// - Instructions accepted whatever the output does.
// - All-ones address changes no register.
// - Rising-edge MSB-first shift, latched on select rise.
// - Readout enable resets to zero.
`default_nettype none

module aas_aux_adc_seq #(
    parameter logic [3:0] CTRL_ADDR = aas_pkg::CTRL_ADDR_DEF
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       cs_n_pin,
    input  wire logic       sclk_pin,
    input  wire logic       din_pin,
    input  wire logic       adc_cmp,
    output logic            dout_o,
    output logic            dout_oe,
    output logic            adc_sample_o,
    output logic [9:0]      adc_trial_o,
    output logic [1:0]      adc_mux_sel_o,
    output logic            adc_ref_sel_o,
    output logic            conv_busy_o,
    output logic            result_ready_o
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic [2:0]                        sync1_reg;
    logic [2:0]                        sync2_reg;
    logic [2:0]                        sync3_reg;
    logic                              cs_n_s;
    logic                              sclk_s;
    logic                              din_s;
    logic                              cs_fall;
    logic                              cs_rise;
    logic                              sclk_rise;
    logic                              sclk_fall;
    logic [aas_pkg::INSTR_W-1:0]       shift_reg;
    logic [aas_pkg::BITCNT_W-1:0]      bitcnt_reg;
    logic                              word_ok;
    logic                              ctrl_wr;
    logic                              launch;
    logic [aas_pkg::CTRL_W-1:0]        ctrl_reg;
    aas_pkg::aas_state_t               state_reg;
    logic                              conv_tick;
    logic [3:0]                        edge_reg;
    logic [aas_pkg::CONV_CNT_W-1:0]    conv_cnt_reg;
    logic [2:0]                        avg_code_reg;
    logic [2:0]                        div_code_reg;
    logic [aas_pkg::RES_W-1:0]         trial_reg;
    logic [aas_pkg::RES_W-1:0]         mask_reg;
    logic [aas_pkg::ACC_W-1:0]         acc_reg;
    logic [aas_pkg::ACC_W-1:0]         acc_sum;
    logic [aas_pkg::RES_W-1:0]         result_reg;
    logic                              ready_reg;
    logic                              last_conv;
    logic                              seq_done;
    logic [aas_pkg::RES_W-1:0]         out_sr_reg;
    logic                              reading_reg;
    logic [2:0]                        avg_sel;
    logic [aas_pkg::RES_W-1:0]         keep_code;

    // ********************************************************************
    // Pin synchronisers and edge detection
    // ********************************************************************

    // Two flops per pin; a third stage holds the previous level for edges.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 3'b011;
            sync2_reg <= 3'b011;
            sync3_reg <= 3'b011;
        end else begin
            sync1_reg <= {din_pin, sclk_pin, cs_n_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Synchronised levels and their edges.
    assign cs_n_s    = sync2_reg[0];
    assign sclk_s    = sync2_reg[1];
    assign din_s     = sync2_reg[2];
    assign cs_fall   = !cs_n_s && sync3_reg[0];
    assign cs_rise   = cs_n_s && !sync3_reg[0];
    assign sclk_rise = !cs_n_s && sclk_s && !sync3_reg[1];
    assign sclk_fall = !cs_n_s && !sclk_s && sync3_reg[1];

    // ********************************************************************
    // Serial instruction input
    // ********************************************************************

    // Instruction bits enter MSB first on rising serial clock edges.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[aas_pkg::INSTR_W-2:0], din_s};
        end
    end

    // Counts bits of the frame, saturating at a full word.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitcnt_reg <= '0;
        end else if (cs_fall) begin
            bitcnt_reg <= '0;
        end else if (sclk_rise && !bitcnt_reg[aas_pkg::BITCNT_W-1]) begin
            bitcnt_reg <= bitcnt_reg + 1'b1;
        end
    end

    // A word is taken on the select rise after at least sixteen bits.
    assign word_ok = cs_rise && bitcnt_reg[aas_pkg::BITCNT_W-1];
    assign ctrl_wr = word_ok
                     && (shift_reg[aas_pkg::ADDR_MSB:aas_pkg::ADDR_LSB] == CTRL_ADDR)
                     && (CTRL_ADDR != aas_pkg::NULL_ADDR);
    assign launch  = ctrl_wr && shift_reg[aas_pkg::START_BIT]
                     && (state_reg == aas_pkg::AAS_IDLE);

    // ********************************************************************
    // Control register
    // ********************************************************************

    // Fields load from the word; the start bit is owned by the sequencer.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= aas_pkg::CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg[aas_pkg::CTRL_W-1:aas_pkg::REF_BIT] <=
                    shift_reg[aas_pkg::CTRL_W-1:aas_pkg::REF_BIT];
            end
            if (launch) begin
                ctrl_reg[aas_pkg::START_BIT] <= 1'b1;
            end else if (seq_done) begin
                ctrl_reg[aas_pkg::START_BIT] <= 1'b0;
            end
        end
    end

    // Reference and input selection follow the register directly.
    assign adc_ref_sel_o = ctrl_reg[aas_pkg::REF_BIT];
    assign adc_mux_sel_o = ctrl_reg[aas_pkg::MUX_LSB +: aas_pkg::MUX_W];
    assign conv_busy_o   = ctrl_reg[aas_pkg::START_BIT];

    // Codes 110 and 111 fall back to thirty-two conversions; read from the launching word.
    assign avg_sel = (shift_reg[aas_pkg::AVG_LSB +: aas_pkg::AVG_W] > aas_pkg::AVG_MAX_CODE)
                     ? aas_pkg::AVG_MAX_CODE
                     : shift_reg[aas_pkg::AVG_LSB +: aas_pkg::AVG_W];

    // ********************************************************************
    // Conversion clock
    // ********************************************************************

    // Settings come from the launching word itself, since the register only takes
    // them on the same edge, and stay frozen so a later write cannot skew a run.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avg_code_reg <= '0;
            div_code_reg <= '0;
        end else if (launch) begin
            avg_code_reg <= avg_sel;
            div_code_reg <= shift_reg[aas_pkg::DIV_LSB +: aas_pkg::DIV_W];
        end
    end

    // One tick per conversion clock edge, from the system clock.
    aas_clk_div #(
        .SEL_W  (aas_pkg::DIV_W)
    ) u_clk_div (
        .clk     (clk),
        .resetn  (resetn),
        .run     (state_reg == aas_pkg::AAS_CONVERT),
        .div_sel (div_code_reg),
        .tick    (conv_tick)
    );

    // ********************************************************************
    // Sequencer
    // ********************************************************************

    // Last conversion of the sequence, and end of the whole averaged sequence.
    assign last_conv = (conv_cnt_reg == aas_pkg::CONV_CNT_W'(
                           ({{(aas_pkg::CONV_CNT_W-1){1'b0}}, 1'b1} << avg_code_reg) - 1'b1));
    assign seq_done  = conv_tick && (edge_reg == aas_pkg::EDGE_LOAD) && last_conv;

    // Idle until launched, back to idle after the last load edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= aas_pkg::AAS_IDLE;
        end else begin
            case (state_reg)
                aas_pkg::AAS_IDLE: begin
                    if (launch) begin
                        state_reg <= aas_pkg::AAS_CONVERT;
                    end
                end
                aas_pkg::AAS_CONVERT: begin
                    if (seq_done) begin
                        state_reg <= aas_pkg::AAS_IDLE;
                    end
                end
                default: begin
                    state_reg <= aas_pkg::AAS_IDLE;
                end
            endcase
        end
    end

    // Edge count within one conversion: sample, ten bits, load.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            edge_reg <= '0;
        end else if (launch) begin
            edge_reg <= aas_pkg::EDGE_SAMPLE;
        end else if (conv_tick) begin
            edge_reg <= (edge_reg == aas_pkg::EDGE_LOAD)
                        ? aas_pkg::EDGE_SAMPLE : edge_reg + 1'b1;
        end
    end

    // Number of conversions completed in this sequence.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_cnt_reg <= '0;
        end else if (launch) begin
            conv_cnt_reg <= '0;
        end else if (conv_tick && edge_reg == aas_pkg::EDGE_LOAD) begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
        end
    end

    // ********************************************************************
    // Successive approximation and averaging
    // ********************************************************************

    // A high comparator means the input is at or above the trial code.
    assign keep_code = adc_cmp ? trial_reg : (trial_reg & ~mask_reg);

    // Trial code and bit mask walk from the MSB down one bit per edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trial_reg <= '0;
            mask_reg  <= '0;
        end else if (conv_tick && edge_reg == aas_pkg::EDGE_SAMPLE) begin
            trial_reg <= {1'b1, {(aas_pkg::RES_W-1){1'b0}}};
            mask_reg  <= {1'b1, {(aas_pkg::RES_W-1){1'b0}}};
        end else if (conv_tick && edge_reg != aas_pkg::EDGE_LOAD) begin
            trial_reg <= keep_code | (mask_reg >> 1);
            mask_reg  <= mask_reg >> 1;
        end
    end

    // Sample strobe to the analog front, one cycle on the sampling edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            adc_sample_o <= 1'b0;
        end else begin
            adc_sample_o <= conv_tick && (edge_reg == aas_pkg::EDGE_SAMPLE);
        end
    end

    assign adc_trial_o = trial_reg;
    assign acc_sum     = acc_reg + aas_pkg::ACC_W'(trial_reg);

    // Accumulate each conversion on its load edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_reg <= '0;
        end else if (launch) begin
            acc_reg <= '0;
        end else if (conv_tick && edge_reg == aas_pkg::EDGE_LOAD) begin
            acc_reg <= acc_sum;
        end
    end

    // Store the truncated mean when the sequence ends; launch clears ready.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_reg <= '0;
            ready_reg  <= 1'b0;
        end else if (seq_done) begin
            result_reg <= aas_pkg::RES_W'(acc_sum >> avg_code_reg);
            ready_reg  <= 1'b1;
        end else if (launch) begin
            ready_reg  <= 1'b0;
        end
    end

    assign result_ready_o = ready_reg;

    // ********************************************************************
    // Serial data output
    // ********************************************************************

    // Drive enable: on at launch, off when chip select rises without a launch.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dout_oe <= 1'b0;
        end else if (launch) begin
            dout_oe <= 1'b1;
        end else if (cs_rise) begin
            dout_oe <= 1'b0;
        end else if (cs_fall && ready_reg && ctrl_reg[aas_pkg::RDEN_BIT]) begin
            dout_oe <= 1'b1;
        end
    end

    // Readout frame runs from a select fall to the next select rise.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reading_reg <= 1'b0;
        end else if (cs_rise) begin
            reading_reg <= 1'b0;
        end else if (cs_fall) begin
            reading_reg <= ready_reg && ctrl_reg[aas_pkg::RDEN_BIT];
        end
    end

    // Output level: busy high, ready low, else result bits MSB first.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dout_o     <= 1'b0;
            out_sr_reg <= '0;
        end else if (launch) begin
            dout_o     <= 1'b1;
        end else if (seq_done) begin
            dout_o     <= 1'b0;
        end else if (cs_fall && ready_reg && ctrl_reg[aas_pkg::RDEN_BIT]) begin
            dout_o     <= result_reg[aas_pkg::RES_W-1];
            out_sr_reg <= result_reg << 1;
        end else if (reading_reg && sclk_fall) begin
            dout_o     <= out_sr_reg[aas_pkg::RES_W-1];
            out_sr_reg <= out_sr_reg << 1;
        end
    end

endmodule

`default_nettype wire

// ===== aas_aux_adc_seq_monitor.sv
// Checker of the sequencer's serial and conversion port behaviour.
`default_nettype none
module aas_aux_adc_seq_monitor (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       cs_n_pin,
    input wire logic       sclk_pin,
    input wire logic       dout_o,
    input wire logic       dout_oe,
    input wire logic       adc_sample_o,
    input wire logic [1:0] adc_mux_sel_o,
    input wire logic       adc_ref_sel_o,
    input wire logic       conv_busy_o,
    input wire logic       result_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cs_hi_cnt;
    logic [3:0] cs_lo_cnt;
    logic [3:0] sclk_lo_cnt;

    // Cycles chip select has rested high or low and the serial clock low, saturating at fifteen.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_hi_cnt   <= 4'h0;
            cs_lo_cnt   <= 4'h0;
            sclk_lo_cnt <= 4'h0;
        end else begin
            cs_hi_cnt   <= cs_n_pin ? cs_hi_cnt + {3'h0, cs_hi_cnt != 4'hF} : 4'h0;
            cs_lo_cnt   <= cs_n_pin ? 4'h0 : cs_lo_cnt + {3'h0, cs_lo_cnt != 4'hF};
            sclk_lo_cnt <= sclk_pin ? 4'h0 : sclk_lo_cnt + {3'h0, sclk_lo_cnt != 4'hF};
        end
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ****************************************
    // Port relations
    // ****************************************
    busy_drive_a: assert property ($rose(conv_busy_o) |-> dout_oe && dout_o)
        else $error("busy start without a driven high output");
    done_ready_a: assert property ($fell(conv_busy_o) |-> result_ready_o && !dout_o)
        else $error("sequence end without ready low output");
    done_only_a: assert property ($fell(conv_busy_o) |-> $rose(result_ready_o))
        else $error("sequence left without a stored result");
    sample_gap_a: assert property (adc_sample_o |=> !adc_sample_o [*8])
        else $error("samples closer than one conversion");
    first_sample_a: assert property ($rose(conv_busy_o) |-> ##[0:130] adc_sample_o)
        else $error("launch without an input sample");
    oe_release_a: assert property ($rose(cs_n_pin) |->
        ##[3:5] (!dout_oe || $rose(conv_busy_o)))
        else $error("output still driven after select rise");
    field_load_a: assert property ($changed({adc_mux_sel_o, adc_ref_sel_o}) |->
        cs_hi_cnt inside {[1:8]})
        else $error("control fields changed away from a frame end");
    shift_fall_a: assert property (dout_oe && $past(dout_oe) && cs_lo_cnt > 4'h6 &&
        $changed(dout_o) && !$fell(conv_busy_o) |-> sclk_lo_cnt inside {[2:7]})
        else $error("result bit changed away from a serial clock fall");
endmodule

bind aas_aux_adc_seq aas_aux_adc_seq_monitor u_mon (
    .clk(clk), .resetn(resetn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .dout_o(dout_o), .dout_oe(dout_oe), .adc_sample_o(adc_sample_o),
    .adc_mux_sel_o(adc_mux_sel_o), .adc_ref_sel_o(adc_ref_sel_o),
    .conv_busy_o(conv_busy_o), .result_ready_o(result_ready_o)
);
`default_nettype wire

// ===== aas_host_model.sv
// Host controller model that drives the three-wire serial port.
`default_nettype none
module aas_host_model (
    input  wire logic clk,
    input  wire logic dout_o,
    input  wire logic dout_oe,
    output var logic  cs_n_pin,
    output var logic  sclk_pin,
    output var logic  din_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;
    wire logic line;

    // A released output line shows the inverse of its last driven level.
    assign line = dout_oe ? dout_o : ~last;

    // Remembers the last driven level of the output line.
    always @(posedge clk) begin
        if (dout_oe === 1'b1) last <= dout_o;
    end

    // Pins idle high so the frame logic sees no false edges.
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b1;
        din_pin  = 1'b1;
        last     = 1'b0;
    end

    // Sends one word, most significant bit first, taken on rising clock edges.
    task automatic send(input logic [15:0] w);
        cs_n_pin = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            din_pin  = w[i];
            sclk_pin = 1'b0;
            repeat (4) @(negedge clk);
            sclk_pin = 1'b1;
            repeat (4) @(negedge clk);
        end
        cs_n_pin = 1'b1;
        din_pin  = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    // Reads ten result bits with the data input held high.
    task automatic read(output logic [9:0] v);
        cs_n_pin = 1'b0;
        din_pin  = 1'b1;
        repeat (8) @(negedge clk);
        v[9] = line;
        for (int i = 8; i >= 0; i--) begin
            sclk_pin = 1'b0;
            repeat (6) @(negedge clk);
            v[i]     = line;
            sclk_pin = 1'b1;
            repeat (4) @(negedge clk);
        end
        cs_n_pin = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ===== aas_pkg.sv
// Constants and types of the auxiliary converter sequencer, and its conversion clock divider.
`default_nettype none

package aas_pkg;

    // ********************************************************************
    // Serial instruction layout
    // ********************************************************************
    localparam int          INSTR_W       = 16;
    localparam int          ADDR_MSB      = 15;
    localparam int          ADDR_LSB      = 12;
    localparam int          BITCNT_W      = 5;
    localparam logic [3:0]  CTRL_ADDR_DEF = 4'h5;
    localparam logic [3:0]  NULL_ADDR     = 4'hF;

    // ********************************************************************
    // Control register fields and reset value
    // ********************************************************************
    localparam int          CTRL_W        = 11;
    localparam int          START_BIT     = 0;
    localparam int          REF_BIT       = 1;
    localparam int          MUX_LSB       = 2;
    localparam int          MUX_W         = 2;
    localparam int          AVG_LSB       = 4;
    localparam int          AVG_W         = 3;
    localparam int          DIV_LSB       = 7;
    localparam int          DIV_W         = 3;
    localparam int          RDEN_BIT      = 10;
    localparam logic [10:0] CTRL_RST      = 11'h000;

    // ********************************************************************
    // Conversion timing and averaging
    // ********************************************************************
    localparam int          RES_W         = 10;
    localparam logic [3:0]  EDGE_SAMPLE   = 4'h0;
    localparam logic [3:0]  EDGE_LOAD     = 4'hB;
    localparam logic [2:0]  AVG_MAX_CODE  = 3'h5;
    localparam int          ACC_W         = 15;
    localparam int          CONV_CNT_W    = 6;

    // Sequencer states.
    typedef enum logic [0:0] {
        AAS_IDLE,
        AAS_CONVERT
    } aas_state_t;

endpackage

// Divides the system clock by two to the power of the selected code.
module aas_clk_div #(
    parameter int SEL_W = 3
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] div_sel,
    output logic                  tick
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] limit;

    // Last count of one conversion clock period.
    assign limit = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << div_sel) - 1'b1);
    assign tick  = run && (cnt_reg == limit);

    // Free count while a sequence runs, restarted when idle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else if (!run || tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the auxiliary converter sequencer.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        resetn;
    logic        adc_cmp;
    wire logic   cs_n_pin;
    wire logic   sclk_pin;
    wire logic   din_pin;
    logic        dout_o;
    logic        dout_oe;
    logic        adc_sample_o;
    logic [9:0]  adc_trial_o;
    logic [1:0]  adc_mux_sel_o;
    logic        adc_ref_sel_o;
    logic        conv_busy_o;
    logic        result_ready_o;
    logic [9:0]  ain [4];
    logic [31:0] seed;
    int          k;
    int          busy_cnt;
    int          cyc;
    int          miscompares;
    int          compares;

    aas_aux_adc_seq DUT (
        .clk(clk), .resetn(resetn), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .din_pin(din_pin), .adc_cmp(adc_cmp), .dout_o(dout_o), .dout_oe(dout_oe),
        .adc_sample_o(adc_sample_o), .adc_trial_o(adc_trial_o),
        .adc_mux_sel_o(adc_mux_sel_o), .adc_ref_sel_o(adc_ref_sel_o),
        .conv_busy_o(conv_busy_o), .result_ready_o(result_ready_o)
    );

    aas_host_model host (
        .clk(clk), .dout_o(dout_o), .dout_oe(dout_oe),
        .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin)
    );

    // System clock of 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Analog side: each sample steps the selected input up by one code.
    always @(negedge clk) begin
        if (resetn === 1'b1) begin
            if (adc_sample_o === 1'b1) k <= k + 1;
            adc_cmp <= (int'(ain[adc_mux_sel_o]) + k) >= int'(adc_trial_o);
        end
    end

    // Cycles the sequence stays busy, and the hang limit.
    always @(posedge clk) begin
        if (conv_busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            results();
        end
    end

    // Xorshift step of the stimulus generator.
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Compares one seen value with its expectation.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One launch, optional rewrites while busy, then completion and readout.
    task automatic run(input logic [2:0] avg, input logic [2:0] div, input logic rden,
                       input logic poke);
        logic [1:0]  mux;
        logic        rf;
        logic [9:0]  s;
        logic [9:0]  v;
        logic [15:0] w;
        int          n;
        seed = xs(seed);
        mux  = seed[1:0];
        rf   = seed[2];
        s    = {1'b0, seed[11:3]};
        n    = (avg > 3'h5) ? 32 : (1 << avg);
        ain[mux] = s;
        k        = 0;
        busy_cnt = 0;
        w = {aas_pkg::CTRL_ADDR_DEF, 1'b0, rden, div, avg, mux, rf, 1'b1};
        host.send(w);
        check({13'h0000, adc_ref_sel_o, adc_mux_sel_o}, {13'h0000, rf, mux});
        check({13'h0000, conv_busy_o, dout_oe, dout_o}, 16'h0007);
        if (poke) begin
            host.send((w & 16'hFFFE) ^ 16'h0002);
            check({14'h0000, conv_busy_o, adc_ref_sel_o}, {14'h0000, 1'b1, ~rf});
            host.send(w);
            check({14'h0000, conv_busy_o, adc_ref_sel_o}, {14'h0000, 1'b1, rf});
        end
        for (int i = 0; i < 20000 && conv_busy_o !== 1'b0; i++) @(negedge clk);
        check(16'(busy_cnt), 16'(12 * n * (1 << div)));
        check({14'h0000, result_ready_o, dout_o}, 16'h0002);
        if (!poke) check({15'h0000, dout_oe}, 16'h0001);
        host.read(v);
        if (rden) check({6'h00, v}, 16'(int'(s) + (n + 1) / 2));
        else check({6'h00, v}, 16'h0000);
        check({15'h0000, dout_oe}, 16'h0000);
    endtask

    // Reset, refused addresses, every averaging code with divider codes 4 to 7, then random runs.
    initial begin
        resetn      = 1'b0;
        adc_cmp     = 1'b0;
        seed        = 32'h0000_AFCB;
        k           = 0;
        busy_cnt    = 0;
        cyc         = 0;
        miscompares = 0;
        compares    = 0;
        for (int i = 0; i < 4; i++) ain[i] = 10'h000;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        check({10'h000, dout_oe, result_ready_o, conv_busy_o, adc_ref_sel_o, adc_mux_sel_o},
              16'h0000);
        host.send(16'hFFFF);
        check({13'h0000, conv_busy_o, adc_mux_sel_o}, 16'h0000);
        host.send(16'h20FF);
        check({13'h0000, conv_busy_o, adc_mux_sel_o}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            run(3'(i), (i < 4) ? 3'(7 - i) : 3'h4, 1'b1, 1'b1);
        end
        repeat (4) begin
            seed = xs(seed);
            run(3'(seed[0]), 3'h4 + 3'(seed[1]), seed[2], 1'b0);
        end
        results();
    end
endmodule
`default_nettype wire
